// file: shared/lpui_regs.svh
`ifndef LPUI_REGS_SVH
`define LPUI_REGS_SVH

// Bus geometry.
`define LPUI_AW 8
`define LPUI_DW 32
`define LPUI_NEV 11

// Register byte offsets.
`define LPUI_FLAG_OFF 8'h2c
`define LPUI_SET_OFF 8'h30
`define LPUI_CLR_OFF 8'h34
`define LPUI_EN_OFF 8'h38

// Event bit positions.
`define LPUI_B_SIG_FRAME 10
`define LPUI_B_START_FRAME 9
`define LPUI_B_ADDR_FRAME 8
`define LPUI_B_FRAME_ERR 7
`define LPUI_B_PARITY_ERR 6
`define LPUI_B_TX_OVER 5
`define LPUI_B_RX_UNDER 4
`define LPUI_B_RX_OVER 3
`define LPUI_B_RX_VALID 2
`define LPUI_B_TX_LEVEL 1
`define LPUI_B_TX_DONE 0

// Bits that the set and clear registers act on; bits 2:1 are reserved there.
`define LPUI_SETCLR_MASK 11'h7f9

// Reset values.
`define LPUI_FLAG_RST 11'h002
`define LPUI_EN_RST 11'h000

// Responses.
`define LPUI_RESP_OKAY 2'h0
`define LPUI_RESP_SLVERR 2'h2

`endif

// file: shared/lpui_pkg.sv
package lpui_pkg;

    typedef struct packed {
        logic [10:0] flag;
        logic [10:0] irq_en;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lpui_state_t;

endpackage : lpui_pkg

// file: hdl/lpui_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lpui_regs.svh"

// Summary of operation
// - Clear-register ones at bits 10, 9, 8 clear signal, start, address-frame flags.
// - Clear-register ones at bits 7 and 6 clear framing and parity error flags.
// - Clear-register ones at bits 5, 4, 3 clear tx overflow, rx underflow, rx overflow.
// - Clear-register bit 0 clears transmit complete; bits 2 and 1 clear nothing.
// - Enable bits 10, 9, 8 are read-write frame-event enables, reset to zero.
// - Enable bits 7 and 6 are read-write error enables, reset to zero.
// - Enable bits 5, 4, 3 are read-write overflow and underflow enables, reset zero.
// - Enable bits 2 and 1 gate receive data valid and transmit buffer level.
// - Enable bit 0 is a read-write transmit complete enable, reset to zero.
// - Set register at 0x030 sets each flag whose bit is written one, except bits 2 and 1.
module lpui_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signal_frame_event,
    input wire logic start_frame_event,
    input wire logic multiproc_address_frame_event,
    input wire logic framing_error_event,
    input wire logic parity_error_event,
    input wire logic transmit_overflow_event,
    input wire logic receive_underflow_event,
    input wire logic receive_overflow_event,
    input wire logic receive_data_valid_event,
    input wire logic transmit_buffer_level_event,
    input wire logic transmit_complete_event,
    output logic irq
);

    localparam lpui_pkg::lpui_state_t RST_STATE = '{
        flag: `LPUI_FLAG_RST,
        irq_en: `LPUI_EN_RST,
        aw_got: 1'b0,
        awaddr: 8'h00,
        w_got: 1'b0,
        wdata: 32'h0000_0000,
        wstrb: 4'h0,
        bvalid: 1'b0,
        bresp: `LPUI_RESP_OKAY,
        rvalid: 1'b0,
        rdata: 32'h0000_0000,
        rresp: `LPUI_RESP_OKAY
    };

    lpui_pkg::lpui_state_t st_r;
    lpui_pkg::lpui_state_t st_nxt;
    logic [10:0] ev;
    logic [10:0] wmask;
    logic [10:0] wd;
    logic do_wr;
    logic ar_hs;
    logic rd_flag;
    logic [10:0] set_v;
    logic [10:0] clr_v;
    logic [10:0] rdclr_v;

    assign ev = {signal_frame_event, start_frame_event, multiproc_address_frame_event,
                 framing_error_event, parity_error_event, transmit_overflow_event,
                 receive_underflow_event, receive_overflow_event,
                 receive_data_valid_event, transmit_buffer_level_event,
                 transmit_complete_event};

    // Byte strobes gate which enable bits a write touches.
    assign wmask = {{3{st_r.wstrb[1]}}, {8{st_r.wstrb[0]}}};
    assign wd = st_r.wdata[10:0] & wmask;

    // A write is carried out in the first cycle that both address and data are held.
    assign do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    assign ar_hs = s_axi_arvalid && s_axi_arready;
    assign rd_flag = ar_hs && (s_axi_araddr[7:2] == `LPUI_FLAG_OFF >> 2);

    assign s_axi_awready = !st_r.aw_got && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_got && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign irq = |(st_r.flag & st_r.irq_en);

    always_comb begin
        st_nxt = st_r;
        set_v = 11'h000;
        clr_v = 11'h000;
        rdclr_v = 11'h000;

        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end

        if (do_wr) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `LPUI_RESP_OKAY;
            // Reserved bits written one are simply ignored.
            unique case ({st_r.awaddr[7:2], 2'b00})
                `LPUI_SET_OFF: begin
                    set_v = wd & `LPUI_SETCLR_MASK;
                end
                `LPUI_CLR_OFF: begin
                    clr_v = wd & `LPUI_SETCLR_MASK;
                end
                `LPUI_EN_OFF: begin
                    st_nxt.irq_en = (st_r.irq_en & ~wmask) | wd;
                end
                `LPUI_FLAG_OFF: begin
                    st_nxt.bresp = `LPUI_RESP_OKAY;
                end
                default: begin
                    st_nxt.bresp = `LPUI_RESP_SLVERR;
                end
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        if (ar_hs) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `LPUI_RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `LPUI_FLAG_OFF: begin
                    st_nxt.rdata[10:0] = st_r.flag;
                    rdclr_v = st_r.flag;
                end
                `LPUI_EN_OFF: begin
                    st_nxt.rdata[10:0] = st_r.irq_en;
                end
                `LPUI_SET_OFF, `LPUI_CLR_OFF: begin
                    st_nxt.rresp = `LPUI_RESP_OKAY;
                end
                default: begin
                    st_nxt.rresp = `LPUI_RESP_SLVERR;
                end
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // Hardware events and software sets win over any clear in the same cycle,
        // so an event is never lost to a racing clear or flag read.
        st_nxt.flag = (st_r.flag & ~clr_v & ~rdclr_v) | ev | set_v;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= RST_STATE;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic is_clr_wr;
    logic is_set_wr;
    logic is_en_wr;
    assign is_clr_wr = do_wr && ({st_r.awaddr[7:2], 2'b00} == `LPUI_CLR_OFF);
    assign is_set_wr = do_wr && ({st_r.awaddr[7:2], 2'b00} == `LPUI_SET_OFF);
    assign is_en_wr = do_wr && ({st_r.awaddr[7:2], 2'b00} == `LPUI_EN_OFF);

    property p_clr(int b);
        is_clr_wr && wd[b] && !ev[b] |=> !st_r.flag[b];
    endproperty

    property p_set(int b);
        is_set_wr && wd[b] |=> st_r.flag[b];
    endproperty

    AST_CLR_SIG_FRAME: assert property (p_clr(10))
        else $error("Signal frame flag not cleared by clear write.");
    AST_CLR_FRAME_ERR: assert property (p_clr(7))
        else $error("Framing error flag not cleared by clear write.");
    AST_CLR_TX_OVER: assert property (p_clr(5))
        else $error("Transmit overflow flag not cleared by clear write.");
    AST_CLR_TX_DONE: assert property (p_clr(0))
        else $error("Transmit complete flag not cleared by clear write.");
    AST_CLR_RSVD: assert property (
        is_clr_wr && !rd_flag |=> (st_r.flag[2:1] & $past(st_r.flag[2:1])) ==
            $past(st_r.flag[2:1]))
        else $error("Reserved clear bits removed a flag.");
    AST_EN_WRITE: assert property (
        is_en_wr && st_r.wstrb[1:0] == 2'h3 |=> st_r.irq_en == $past(wd))
        else $error("Enable register did not take written value.");
    AST_EN_HOLD: assert property (
        !is_en_wr |=> $stable(st_r.irq_en))
        else $error("Enable register changed without a write.");
    // Reset itself is the antecedent here, so this one must not be disabled by it.
    AST_EN_RESET: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> st_r.irq_en == 11'h000)
        else $error("Enable register not zero after reset.");
    AST_SET_SIG_FRAME: assert property (p_set(10))
        else $error("Set write did not raise the flag.");
    AST_ZERO_CLR: assert property (
        is_clr_wr && wd == 11'h000 && ev == 11'h000 && !rd_flag |=> $stable(st_r.flag))
        else $error("Writing zeros to clear register changed flags.");
    AST_IRQ_CAUSE: assert property (
        is_en_wr && st_r.wstrb[1:0] == 2'h3 && |(st_r.flag & wd) |=> irq)
        else $error("Interrupt not raised for enabled pending flag.");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("Write response dropped before it was taken.");

    COV_CLR: cover property (is_clr_wr ##1 s_axi_bvalid);
    COV_FLAG_READ: cover property (rd_flag ##1 s_axi_rvalid);
    COV_IRQ: cover property ($rose(irq));
    COV_SET_RACE: cover property (is_clr_wr && |(ev & wd));

endmodule : lpui_top

`default_nettype wire

// file: sim/lpui_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "lpui_regs.svh"
module lpui_top_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [10:0] ev;
    int fail_count, n_tests;

    lpui_top lpui_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .signal_frame_event(ev[`LPUI_B_SIG_FRAME]),
        .start_frame_event(ev[`LPUI_B_START_FRAME]),
        .multiproc_address_frame_event(ev[`LPUI_B_ADDR_FRAME]),
        .framing_error_event(ev[`LPUI_B_FRAME_ERR]),
        .parity_error_event(ev[`LPUI_B_PARITY_ERR]),
        .transmit_overflow_event(ev[`LPUI_B_TX_OVER]),
        .receive_underflow_event(ev[`LPUI_B_RX_UNDER]),
        .receive_overflow_event(ev[`LPUI_B_RX_OVER]),
        .receive_data_valid_event(ev[`LPUI_B_RX_VALID]),
        .transmit_buffer_level_event(ev[`LPUI_B_TX_LEVEL]),
        .transmit_complete_event(ev[`LPUI_B_TX_DONE]), .irq(irq));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic finish_test();
        if (fail_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic hang();
        chk("handshake", 32'h1, 32'h0);
        finish_test();
    endtask : hang

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) hang();
    endtask : axi_rd

    task automatic chk_irq(input logic e);
        #1;
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : chk_irq

    task automatic pulse(input int b);
        @(posedge aclk);
        ev <= 11'h001 << b;
        @(posedge aclk);
        ev <= 11'h000;
    endtask : pulse

    task automatic t_reset_rw();
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(`LPUI_EN_OFF, d, r);
        chk("enable reset", 32'h0, d);
        axi_rd(`LPUI_FLAG_OFF, d, r);
        chk("flag reset", 32'h2, d);
        axi_wr(`LPUI_EN_OFF, 32'h7ff, r);
        axi_rd(`LPUI_EN_OFF, d, r);
        chk("enable all", 32'h7ff, d);
        axi_wr(`LPUI_EN_OFF, 32'h2aa, r);
        axi_rd(`LPUI_EN_OFF, d, r);
        chk("enable alt", 32'h2aa, d);
        axi_rd(`LPUI_CLR_OFF, d, r);
        chk("clear reads zero", 32'h0, d);
        axi_wr(8'h40, 32'h1, r);
        chk("unmapped write", 32'h2, {30'h0, r});
        axi_rd(8'h40, d, r);
        chk("unmapped read", 32'h2, {30'h0, r});
    endtask : t_reset_rw

    task automatic t_events();
        logic [31:0] d;
        logic [1:0] r;
        axi_wr(`LPUI_EN_OFF, 32'h0, r);
        for (int i = 0; i < 11; i++) begin
            axi_rd(`LPUI_FLAG_OFF, d, r);
            pulse(i);
            chk_irq(1'b0);
            axi_rd(`LPUI_FLAG_OFF, d, r);
            chk("event flag", 32'h1 << i, d);
        end
    endtask : t_events

    // Reserved clear bits 2:1 can only be reached through event inputs.
    task automatic t_clear();
        logic [31:0] d;
        logic [1:0] r;
        logic live;
        for (int b = 0; b < 11; b++) begin
            live = ((`LPUI_SETCLR_MASK >> b) & 11'h001) != 11'h000;
            if (live) axi_wr(`LPUI_SET_OFF, 32'h1 << b, r);
            else pulse(b);
            axi_wr(`LPUI_EN_OFF, 32'h1 << b, r);
            chk_irq(1'b1);
            axi_wr(`LPUI_CLR_OFF, 32'h0, r);
            chk_irq(1'b1);
            // Reserved clear bits are never written one; the other bits must spare them.
            axi_wr(`LPUI_CLR_OFF, live ? 32'h1 << b : `LPUI_SETCLR_MASK, r);
            chk_irq(~live);
            axi_rd(`LPUI_FLAG_OFF, d, r);
            chk("flag after clear", live ? 32'h0 : 32'h1 << b, d);
        end
    endtask : t_clear

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        ev = 11'h000;
        fail_count = 0;
        n_tests = 0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_rw();
        t_events();
        t_clear();
        finish_test();
    end
endmodule : lpui_top_tb_top
`default_nettype wire
